// file: pkg/conv_host_pkg.sv
// Package of constants and types for the converter host controller.
package conv_host_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS      = 10;
  localparam int SAMPLE_LOW_NS      = 250;
  localparam int SAMPLE_LOW_CYC     = (SAMPLE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_TYP_NS        = 600;
  localparam int RDSTART_TYP_NS     = 850;
  localparam int DATA_VALID_NS      = 20;
  localparam int DATA_VALID_CYC     = (DATA_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_LOW_NS        = 50;
  localparam int READ_LOW_CYC       = (READ_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMEOUT_NS         = 2000;
  localparam int TIMEOUT_CYC        = TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int CNT_W              = 8;

  // ****************************************************************
  // Result and channel layout
  // ****************************************************************
  localparam int RES_W       = 10;
  localparam int UPPER_LSB   = 4;
  localparam int CHAN_W      = 2;
  localparam logic [RES_W-1:0] RES_RESET = 10'h000;
  localparam logic [RES_W-1:0] RES_MAX   = 10'h3ff;

  // ****************************************************************
  // Modes and states
  // ****************************************************************
  typedef enum logic {MODE_SEPARATE, MODE_RDSTART} conv_mode_t;

  typedef enum {ST_IDLE, ST_SAMPLE, ST_WAIT, ST_READ, ST_SETTLE, ST_DONE} host_state_t;

endpackage

// file: verilog/pulse_timer.sv
// Down-counting interval timer that flags when a loaded count expires.
`timescale 1ns/1ns
`default_nettype none
module pulse_timer
  import conv_host_pkg::*;
(
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Control
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] count,
  // Status
  output logic                  expired
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } tmr_t;

  tmr_t st_r;
  tmr_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (load) begin
      st_nxt.cnt = count;
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Expiry flags whenever the count is zero, including straight after reset, but not while loading.
  assign expired = (st_r.cnt == '0) && !load;

endmodule
`default_nettype wire

// file: verilog/conv_host.sv
// Host controller that sequences conversions on a two-step flash converter.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Separate mode: host holds sample strobe low with select low for 26 cycles (260 ns).
// - After completion, host reads result by pulling read low with select low.
// - Channel taken from select lines at sample falling edge, high:low gives 0..3.
// - Read-start mode: host starts conversion pulling the joined strobe low.
module conv_host
  import conv_host_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // User command side
  input  wire logic              start,
  input  wire conv_mode_t        mode,
  input  wire logic [CHAN_W-1:0] channel,
  output logic                   busy,
  output logic                   result_valid,
  output logic [RES_W-1:0]       result,
  output logic [CHAN_W-1:0]      result_chan,
  output logic                   timeout,
  // Converter pins
  output logic                   chip_sel_n,
  output logic                   sample_n,
  output logic                   read_n,
  output logic                   chan_sel_lo,
  output logic                   chan_sel_hi,
  input  wire logic              conv_done_n,
  input  wire logic [RES_W-1:0]  result_bus
);

  typedef struct packed {
    host_state_t       state;
    conv_mode_t        mode;
    logic [CNT_W-1:0]  guard;
    logic              busy;
    logic              valid;
    logic [RES_W-1:0]  result;
    logic [CHAN_W-1:0] chan;
    logic              timeout;
    logic              cs_n;
    logic              sh_n;
    logic              rd_n;
  } host_st_t;

  host_st_t st_r;
  host_st_t st_nxt;

  logic             tmr_load;
  logic [CNT_W-1:0] tmr_count;
  logic             tmr_expired;

  pulse_timer u_timer (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .load     (tmr_load),
    .count    (tmr_count),
    .expired  (tmr_expired)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    st_nxt    = st_r;
    tmr_load  = 1'b0;
    tmr_count = '0;
    st_nxt.valid = 1'b0;
    case (st_r.state)
      ST_IDLE: begin
        st_nxt.cs_n = 1'b1;
        st_nxt.sh_n = 1'b1;
        st_nxt.rd_n = 1'b1;
        st_nxt.busy = 1'b0;
        if (start) begin
          // Channel lines move on the strobe edge, so a slow select path needs extra setup
          st_nxt.chan    = channel;
          st_nxt.mode    = mode;
          st_nxt.busy    = 1'b1;
          st_nxt.timeout = 1'b0;
          st_nxt.cs_n    = 1'b0;
          st_nxt.sh_n    = 1'b0;
          st_nxt.rd_n    = (mode == MODE_RDSTART) ? 1'b0 : 1'b1;
          st_nxt.guard   = CNT_W'(TIMEOUT_CYC);
          tmr_load       = 1'b1;
          tmr_count      = CNT_W'(SAMPLE_LOW_CYC);
          st_nxt.state   = (mode == MODE_RDSTART) ? ST_WAIT : ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        // Held low at least the minimum sample time
        if (tmr_expired) begin
          st_nxt.sh_n  = 1'b1;
          st_nxt.state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // The device's own timer runs the fine step; the host waits while counting down its timeout guard.
        st_nxt.guard = st_r.guard - 1'b1;
        if (!conv_done_n) begin
          if (st_r.mode == MODE_RDSTART) begin
            tmr_load     = 1'b1;
            tmr_count    = CNT_W'(DATA_VALID_CYC);
            st_nxt.state = ST_SETTLE;
          end else begin
            st_nxt.rd_n  = 1'b0;
            tmr_load     = 1'b1;
            tmr_count    = CNT_W'(READ_LOW_CYC);
            st_nxt.state = ST_SETTLE;
          end
        end else if (st_r.guard == '0) begin
          st_nxt.timeout = 1'b1;
          st_nxt.state   = ST_DONE;
        end
      end
      ST_SETTLE: begin
        // Old data is on the pins until after completion, so wait before capture
        if (tmr_expired) begin
          st_nxt.result = result_bus;
          st_nxt.valid  = 1'b1;
          st_nxt.state  = ST_DONE;
        end
      end
      ST_DONE: begin
        // Raising read releases completion on the device
        st_nxt.rd_n  = 1'b1;
        st_nxt.sh_n  = 1'b1;
        st_nxt.cs_n  = 1'b1;
        st_nxt.busy  = 1'b0;
        st_nxt.state = ST_IDLE;
      end
      default: begin
        st_nxt.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '{state: ST_IDLE, mode: MODE_SEPARATE, guard: '0, busy: 1'b0,
                valid: 1'b0, result: RES_RESET, chan: '0, timeout: 1'b0,
                cs_n: 1'b1, sh_n: 1'b1, rd_n: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign busy         = st_r.busy;
  assign result_valid = st_r.valid;
  assign result       = st_r.result;
  assign result_chan  = st_r.chan;
  assign timeout      = st_r.timeout;
  assign chip_sel_n   = st_r.cs_n;
  assign sample_n     = st_r.sh_n;
  assign read_n       = st_r.rd_n;
  assign chan_sel_lo  = st_r.chan[0];
  assign chan_sel_hi  = st_r.chan[1];

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [CNT_W-1:0] low_cnt_r;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_cnt_r <= '0;
    end else if (!sample_n) begin
      low_cnt_r <= low_cnt_r + 1'b1;
    end else begin
      low_cnt_r <= '0;
    end
  end

  sample_width_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(sample_n) && st_r.mode == MODE_SEPARATE |-> $past(low_cnt_r) >= CNT_W'(SAMPLE_LOW_CYC - 1))
    else $error("Sample strobe low too short.");

  select_gates_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!sample_n || !read_n) |-> !chip_sel_n)
    else $error("Strobe low without chip select.");

  chan_stable_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !sample_n |-> $stable({chan_sel_hi, chan_sel_lo}) || $fell(sample_n))
    else $error("Channel lines moved while sampling.");

  read_after_done_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(read_n) && st_r.mode == MODE_SEPARATE |-> !$past(conv_done_n))
    else $error("Read started before completion.");

  joined_strobe_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(sample_n) && st_r.mode == MODE_RDSTART |-> !read_n)
    else $error("Joined strobes did not fall together.");

  capture_delay_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    result_valid && st_r.mode == MODE_RDSTART |-> !$past(conv_done_n, 3))
    else $error("Result captured before data settled.");

  read_release_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    result_valid |=> read_n && sample_n && chip_sel_n)
    else $error("Strobes not released after capture.");

  busy_bound_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(busy) |-> ##[1:230] !busy)
    else $error("Conversion did not finish in time.");

  cover_separate_c: cover property (@(posedge core_clk) disable iff (sys_rst)
    result_valid && st_r.mode == MODE_SEPARATE);
  cover_rdstart_c: cover property (@(posedge core_clk) disable iff (sys_rst)
    result_valid && st_r.mode == MODE_RDSTART);
  cover_timeout_c: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(timeout));
  cover_refused_c: cover property (@(posedge core_clk) disable iff (sys_rst) start && busy);

endmodule
`default_nettype wire

// file: tb/conv_dev_model.sv
// Behavioural model of the two-step flash converter seen from its host pins.
`timescale 1ns/1ns
`default_nettype none
module conv_dev_model
  import conv_host_pkg::*;
(
  // Host pins
  input  wire logic               chip_sel_n,
  input  wire logic               sample_n,
  input  wire logic               read_n,
  input  wire logic               chan_sel_lo,
  input  wire logic               chan_sel_hi,
  output logic                    conv_done_n,
  output logic [RES_W-1:0]        result_bus,
  // Bench controls
  input  wire logic               joined,
  input  wire logic               slow,
  input  wire logic               mute,
  input  wire logic [4*RES_W-1:0] codes
);
  logic [RES_W-1:0]  out_r;
  logic [CHAN_W-1:0] chan_r;
  int unsigned       tag_r;
  wire smp_n = chip_sel_n | sample_n;
  wire rd_n  = chip_sel_n | read_n;

  // Stale tags drop late completions after a newer sample edge.
  task automatic finish(input int unsigned t, input int d);
    #(d + 3);
    if (t == tag_r && !mute) begin
      if (!joined) out_r = codes[chan_r*RES_W +: RES_W];
      conv_done_n = 1'b0;
      if (joined) #(DATA_VALID_NS) out_r = codes[chan_r*RES_W +: RES_W];
    end
  endtask

  initial begin
    conv_done_n = 1'b1;
    out_r = RES_RESET;
    tag_r = 0;
    chan_r = '0;
  end
  // The host moves the select lines on the strobe edge, so they are read just inside the hold window.
  always @(negedge smp_n) begin
    tag_r++;
    if (joined) fork finish(tag_r, RDSTART_TYP_NS + (slow ? 400 : 0)); join_none
    #1 chan_r = {chan_sel_hi, chan_sel_lo};
  end
  always @(posedge smp_n) begin
    if (!joined) fork finish(tag_r, CONV_TYP_NS + (slow ? 400 : 0)); join_none
  end
  always @(posedge rd_n) conv_done_n = 1'b1;
  // Released pins show the inverse so a stale value never reads as good.
  assign result_bus = rd_n ? ~out_r : out_r;
endmodule
`default_nettype wire

// file: tb/multistep_adc_host_interface_bench.sv
// Self-checking bench for the converter host controller.
`timescale 1ns/1ns
`default_nettype none
module multistep_adc_host_interface_bench;
  import conv_host_pkg::*;
  logic               core_clk, sys_rst, start, busy, result_valid, timeout;
  logic               chip_sel_n, sample_n, read_n, chan_sel_lo, chan_sel_hi, conv_done_n;
  logic               slow, mute;
  conv_mode_t         mode;
  logic [CHAN_W-1:0]  channel, result_chan;
  logic [RES_W-1:0]   result, result_bus;
  logic [4*RES_W-1:0] codes;
  logic [RES_W+CHAN_W-1:0] exp_q[$];
  logic [RES_W+CHAN_W-1:0] ev;
  logic [63:0]        rnd;
  int                 seed, err_total, comparisons, low_cnt;

  conv_host dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .start(start), .mode(mode),
    .channel(channel), .busy(busy), .result_valid(result_valid), .result(result),
    .result_chan(result_chan), .timeout(timeout), .chip_sel_n(chip_sel_n),
    .sample_n(sample_n), .read_n(read_n), .chan_sel_lo(chan_sel_lo),
    .chan_sel_hi(chan_sel_hi), .conv_done_n(conv_done_n), .result_bus(result_bus));
  conv_dev_model dev_u (.chip_sel_n(chip_sel_n), .sample_n(sample_n), .read_n(read_n),
    .chan_sel_lo(chan_sel_lo), .chan_sel_hi(chan_sel_hi), .conv_done_n(conv_done_n),
    .result_bus(result_bus), .joined(mode == MODE_RDSTART), .slow(slow), .mute(mute),
    .codes(codes));

  task note(input string msg);
    err_total++;
    $display("MISMATCH %0t %s", $time, msg);
  endtask

  task wrap_up;
    if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // A second start while busy must be ignored, so each run pulses it twice.
  task run_conv(input conv_mode_t m, input logic [1:0] ch, input logic sl, input logic mu,
                input logic [4*RES_W-1:0] cd);
    int n;
    @(negedge core_clk);
    mode = m;
    channel = ch;
    slow = sl;
    mute = mu;
    codes = cd;
    if (!mu) exp_q.push_back({cd[ch*RES_W +: RES_W], ch});
    start = 1'b1;
    @(negedge core_clk) start = 1'b0;
    repeat (3) @(negedge core_clk);
    channel = ~ch;
    start = 1'b1;
    @(negedge core_clk) start = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    comparisons++;
    if (n >= 400 || timeout !== mu) note("busy or timeout flag wrong");
  endtask

  initial begin
    core_clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
  end

  // Outputs are looked at on the falling edge, where they have settled.
  always @(negedge core_clk) begin
    if (result_valid === 1'b1) begin
      if (exp_q.size() == 0) note("unexpected result");
      else begin
        ev = exp_q.pop_front();
        comparisons++;
        if (result !== ev[RES_W+CHAN_W-1:CHAN_W]) note("result wrong");
        if (result_chan !== ev[CHAN_W-1:0]) note("channel wrong");
      end
    end
    if (sample_n === 1'b0) begin
      low_cnt++;
      if (chip_sel_n !== 1'b0) note("sample strobe without select");
    end else if (low_cnt != 0) begin
      comparisons++;
      if (mode == MODE_SEPARATE && low_cnt < SAMPLE_LOW_CYC) note("sample strobe too short");
      low_cnt = 0;
    end
    if (mode == MODE_SEPARATE && read_n === 1'b0 && conv_done_n !== 1'b0) begin
      note("read before completion");
    end
    if (mode == MODE_RDSTART && busy === 1'b1 && sample_n !== read_n) note("joined strobes differ");
  end

  initial begin
    #(200000);
    note("watchdog expired");
    wrap_up();
  end

  initial begin
    seed = 32'h3887f10b;
    err_total = 0;
    comparisons = 0;
    low_cnt = 0;
    sys_rst = 1'b1;
    start = 1'b0;
    mode = MODE_SEPARATE;
    channel = 2'h0;
    slow = 1'b0;
    mute = 1'b0;
    codes = '0;
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      rnd = i[0] ? '1 : '0;
      run_conv(conv_mode_t'(i[1]), i[2:1], i[2], 1'b0, rnd[4*RES_W-1:0]);
    end
    run_conv(MODE_SEPARATE, 2'h2, 1'b0, 1'b1, '0);
    for (int i = 0; i < 12; i++) begin
      rnd = {$random(seed), $random(seed)};
      run_conv(conv_mode_t'(rnd[63]), rnd[61:60], rnd[59], 1'b0, rnd[4*RES_W-1:0]);
    end
    repeat (5) @(negedge core_clk);
    comparisons++;
    if (exp_q.size() != 0) note("result missing");
    wrap_up();
  end
endmodule
`default_nettype wire
